// ### src/cfcc_core.sv
/*
  Instruction cycle sequencer and status flag register of the core.
  Assumes one classified instruction offered per handshake, skip condition
  and ALU flags valid alongside it, synchronous to ref_clk_in.
*/
// What this block does
// - Branches and indexed access take two cycles
// - Skips take two cycles only when skipping
// - Arith all flags, logic Z, shifts C
// - Bit access on RAM only 0x00-0x3F
`timescale 1ns/1ps
module cfcc_core
  import cfcc_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  // Instruction offer
  input  wire logic                  instr_valid_in,
  input  wire cfcc_class_t           instr_class_in,
  input  wire logic                  skip_cond_in,
  input  wire logic [BIT_ADDR_W-1:0] bit_addr_in,
  // Flag sources
  input  wire cfcc_flags_t           alu_flags_in,
  input  wire cfcc_flags_t           stack_flags_in,
  // Status
  output logic                       instr_ready_out,
  output logic                       retire_out,
  output logic [1:0]                 cycles_out,
  output cfcc_flags_t                flags_out,
  output logic                       bit_grant_out,
  output logic                       bit_fault_out
);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {ST_RUN, ST_EXTRA} cfcc_state_t;

  cfcc_state_t state_reg, state_next;
  logic        ready_reg, ready_next;
  logic        retire_reg, retire_next;
  logic [1:0]  cycles_reg, cycles_next;
  logic        grant_reg, grant_next;
  logic        fault_reg, fault_next;
  logic        take;
  logic        addr_ok;
  logic        two_cyc;

  assign take    = instr_valid_in && ready_reg;
  assign addr_ok = bit_addr_ok(bit_addr_in);

  always_comb
  begin
    two_cyc     = 1'b0;
    state_next  = state_reg;
    ready_next  = ready_reg;
    retire_next = 1'b0;
    cycles_next = cycles_reg;
    grant_next  = 1'b0;
    fault_next  = 1'b0;
    case (state_reg)
      ST_RUN:
      begin
        if (take)
        begin
          if (is_fixed_two(instr_class_in))
            two_cyc = 1'b1;
          else if (is_skip(instr_class_in))
            // An out-of-window RAM bit test never skips
            two_cyc = skip_cond_in && !(instr_class_in == CL_BIT_SKIP_MEM
                      && !addr_ok);
          if (is_bit_mem(instr_class_in))
          begin
            grant_next = addr_ok;
            fault_next = !addr_ok;
          end
          cycles_next = two_cyc ? CYC_TWO : CYC_ONE;
          if (two_cyc)
          begin
            state_next = ST_EXTRA;
            ready_next = 1'b0;
          end
          else
            retire_next = 1'b1;
        end
      end
      ST_EXTRA:
      begin
        state_next  = ST_RUN;
        ready_next  = 1'b1;
        retire_next = 1'b1;
      end
      default:
      begin
        state_next = ST_RUN;
        ready_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg  <= ST_RUN;
      ready_reg  <= 1'b1;
      retire_reg <= 1'b0;
      cycles_reg <= CYC_RST;
      grant_reg  <= 1'b0;
      fault_reg  <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      ready_reg  <= ready_next;
      retire_reg <= retire_next;
      cycles_reg <= cycles_next;
      grant_reg  <= grant_next;
      fault_reg  <= fault_next;
    end
  end

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  cfcc_flags_t flags_reg, flags_next, flags_sel;
  cfcc_class_t upd_class;

  // Idle cycles and refused offers must not touch the flags
  always_comb
  begin
    upd_class = instr_class_in;
    if (!take)
      upd_class = CL_OTHER_NOFLAG;
  end

  cfcc_flag_sel cfcc_flag_sel_inst (
    .cls_in   (upd_class),
    .cur_in   (flags_reg),
    .alu_in   (alu_flags_in),
    .stack_in (stack_flags_in),
    .next_out (flags_sel)
  );

  always_comb
  begin
    flags_next = flags_sel;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      flags_reg <= FLAGS_RST;
    else
      flags_reg <= flags_next;
  end

  assign instr_ready_out = ready_reg;
  assign retire_out      = retire_reg;
  assign cycles_out      = cycles_reg;
  assign flags_out       = flags_reg;
  assign bit_grant_out   = grant_reg;
  assign bit_fault_out   = fault_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  AST_BRANCH_TWO: assert property (
    take && is_fixed_two(instr_class_in)
    |=> !instr_ready_out && !retire_out && cycles_out == CYC_TWO
        ##1 retire_out && instr_ready_out)
    else $error("branch did not take two cycles");

  AST_PLAIN_ONE: assert property (
    take && (instr_class_in inside {CL_ARITH, CL_LOGIC, CL_SHIFT,
                                    CL_OTHER_NOFLAG, CL_POP_FLAGS})
    |=> retire_out && instr_ready_out && cycles_out == CYC_ONE)
    else $error("plain instruction did not take one cycle");

  AST_SKIP_TAKEN: assert property (
    take && (instr_class_in inside {CL_CMP_SKIP, CL_CNT_SKIP,
                                    CL_BIT_SKIP_IO}) && skip_cond_in
    |=> !retire_out ##1 retire_out && cycles_out == CYC_TWO)
    else $error("taken skip did not take two cycles");

  AST_SKIP_NOT: assert property (
    take && is_skip(instr_class_in) && !skip_cond_in
    |=> retire_out && cycles_out == CYC_ONE)
    else $error("untaken skip did not take one cycle");

  AST_ARITH_FLAGS: assert property (
    take && (instr_class_in inside {CL_ARITH, CL_CMP_SKIP, CL_CNT_SKIP})
    |=> flags_out == $past(alu_flags_in))
    else $error("arith flags not all updated");

  AST_LOGIC_Z: assert property (
    take && (instr_class_in inside {CL_LOGIC, CL_LOAD_ACC})
    |=> flags_out.zero_flag == $past(alu_flags_in.zero_flag) &&
        flags_out[2:0] == $past(flags_out[2:0]))
    else $error("logic op flag update wrong");

  AST_SHIFT_C: assert property (
    take && (instr_class_in inside {CL_SHIFT, CL_SWAP_CARRY})
    |=> flags_out.carry_flag == $past(alu_flags_in.carry_flag) &&
        flags_out.zero_flag == $past(flags_out.zero_flag) &&
        flags_out[1:0] == $past(flags_out[1:0]))
    else $error("shift flag update wrong");

  AST_POP_FLAGS: assert property (
    take && instr_class_in == CL_POP_FLAGS
    |=> flags_out == $past(stack_flags_in))
    else $error("pop did not restore flags");

  AST_NOFLAG_HOLD: assert property (
    (!take || instr_class_in inside {CL_OTHER_NOFLAG, CL_BRANCH,
      CL_INDEXED, CL_BIT_SKIP_IO, CL_BIT_SKIP_MEM, CL_BIT_WRITE_MEM})
    |=> $stable(flags_out))
    else $error("flags changed unexpectedly");

  AST_BIT_WINDOW: assert property (
    take && is_bit_mem(instr_class_in)
    |=> bit_fault_out == ($past(bit_addr_in) > BIT_ADDR_MAX) &&
        bit_grant_out == !bit_fault_out)
    else $error("bit window check wrong");

  CVR_BRANCH: cover property (take && instr_class_in == CL_BRANCH);
  CVR_SKIP:   cover property (take && is_skip(instr_class_in) &&
                              skip_cond_in ##2 retire_out);
  CVR_FAULT:  cover property (bit_fault_out);
  CVR_POP:    cover property (take && instr_class_in == CL_POP_FLAGS);

endmodule : cfcc_core

// ### src/cfcc_pkg.sv
/*
  Shared types and constants for the cycle and flag control block.
  Assumes a decoder upstream that classifies each opcode into one class.
*/
package cfcc_pkg;

  // ---------------------------------------------------------------
  // Instruction classes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CL_OTHER_NOFLAG,   // mov to mem/IO, xch, set/clear bit, xor IO, misc
    CL_BRANCH,         // goto, call, pcadd, ret, reti
    CL_INDEXED,        // indexed memory access
    CL_ARITH,          // add, sub, inc, dec and carry forms
    CL_LOGIC,          // and, or, xor, not, neg
    CL_LOAD_ACC,       // load accumulator from memory or IO
    CL_SHIFT,          // shifts and rotates
    CL_SWAP_CARRY,     // bit carry swap on IO
    CL_POP_FLAGS,      // pop accumulator and flags
    CL_CMP_SKIP,       // compare and skip
    CL_CNT_SKIP,       // count and skip on zero
    CL_BIT_SKIP_IO,    // bit_clear_test_skip / bit_set_test_skip on IO
    CL_BIT_SKIP_MEM,   // bit_clear_test_skip / bit_set_test_skip on RAM
    CL_BIT_WRITE_MEM   // single bit set or clear on RAM
  } cfcc_class_t;

  typedef struct packed {
    logic zero_flag;
    logic carry_flag;
    logic auxiliary_carry_flag;
    logic overflow_flag;
  } cfcc_flags_t;

  // ---------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------
  localparam int          BIT_ADDR_W   = 8;
  localparam logic [7:0]  BIT_ADDR_MIN = 8'h00;
  localparam logic [7:0]  BIT_ADDR_MAX = 8'h3F;
  localparam logic [1:0]  CYC_ONE      = 2'h1;
  localparam logic [1:0]  CYC_TWO      = 2'h2;
  localparam logic [1:0]  CYC_RST      = 2'h0;
  localparam cfcc_flags_t FLAGS_RST    = 4'h0;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_fixed_two(input cfcc_class_t cl);
    return (cl == CL_BRANCH) || (cl == CL_INDEXED);
  endfunction : is_fixed_two

  function automatic logic is_skip(input cfcc_class_t cl);
    return (cl == CL_CMP_SKIP) || (cl == CL_CNT_SKIP) ||
           (cl == CL_BIT_SKIP_IO) || (cl == CL_BIT_SKIP_MEM);
  endfunction : is_skip

  function automatic logic is_bit_mem(input cfcc_class_t cl);
    return (cl == CL_BIT_SKIP_MEM) || (cl == CL_BIT_WRITE_MEM);
  endfunction : is_bit_mem

  function automatic logic bit_addr_ok(input logic [BIT_ADDR_W-1:0] a);
    return (a >= BIT_ADDR_MIN) && (a <= BIT_ADDR_MAX);
  endfunction : bit_addr_ok

endpackage : cfcc_pkg

// ### src/cfcc_flag_sel.sv
/*
  Flag selector: picks the next flag set for one instruction class.
  Assumes the ALU and stack values are valid while the class is presented.
*/
`timescale 1ns/1ps
module cfcc_flag_sel
  import cfcc_pkg::*;
(
  // Instruction
  input  wire cfcc_class_t cls_in,
  // Flag sources
  input  wire cfcc_flags_t cur_in,
  input  wire cfcc_flags_t alu_in,
  input  wire cfcc_flags_t stack_in,
  // Result
  output cfcc_flags_t      next_out
);

  always_comb
  begin
    next_out = cur_in;
    case (cls_in)
      CL_ARITH, CL_CMP_SKIP, CL_CNT_SKIP:
        next_out = alu_in;
      CL_LOGIC, CL_LOAD_ACC:
        next_out.zero_flag = alu_in.zero_flag;
      CL_SHIFT, CL_SWAP_CARRY:
        next_out.carry_flag = alu_in.carry_flag;
      CL_POP_FLAGS:
        next_out = stack_in;
      default:
        next_out = cur_in;
    endcase
  end

endmodule : cfcc_flag_sel

// ### verif/cfcc_core_bench.sv
/*
  Self-checking bench for the cycle and flag control core.
  Assumes the core's own assertions run inside it; the bench only drives
  classified instructions and predicts lengths, flags and bit grants.
*/
`timescale 1ns/1ps
module cfcc_core_bench
  import cfcc_pkg::*;
();
  typedef struct packed {
    logic [1:0]  cyc;
    cfcc_flags_t fl;
    logic        grant;
    logic        fault;
  } cfcc_exp_t;

  logic                  ref_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  valid = 1'b0;
  cfcc_class_t           cls = CL_OTHER_NOFLAG;
  logic                  skip = 1'b0;
  logic [BIT_ADDR_W-1:0] addr = 8'h00;
  cfcc_flags_t           alu = 4'h0;
  cfcc_flags_t           stk = 4'h0;
  logic                  ready;
  logic                  retire;
  logic [1:0]            cycles;
  cfcc_flags_t           flags;
  logic                  grant;
  logic                  fault;
  cfcc_exp_t             exp_q[$];
  cfcc_flags_t           model_fl = 4'h0;
  logic                  g_acc = 1'b0;
  logic                  f_acc = 1'b0;
  int                    n_fail = 0;
  int                    samples_checked = 0;
  integer                seed = 32'h269f;

  always #2.5 ref_clk = ~ref_clk;

  cfcc_core cfcc_core_inst (
    .ref_clk_in      (ref_clk),
    .rst_in          (rst),
    .instr_valid_in  (valid),
    .instr_class_in  (cls),
    .skip_cond_in    (skip),
    .bit_addr_in     (addr),
    .alu_flags_in    (alu),
    .stack_flags_in  (stk),
    .instr_ready_out (ready),
    .retire_out      (retire),
    .cycles_out      (cycles),
    .flags_out       (flags),
    .bit_grant_out   (grant),
    .bit_fault_out   (fault)
  );

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // Bit grant may lead retire by a cycle on two-cycle ops, so accumulate
  always @(negedge ref_clk)
  begin
    cfcc_exp_t e;
    if (!rst)
    begin
      g_acc = g_acc | grant;
      f_acc = f_acc | fault;
      if (retire === 1'b1)
      begin
        if (exp_q.size() == 0)
          check(8'hEE, 8'h00);
        else
        begin
          e = exp_q.pop_front();
          check({6'h0, cycles}, {6'h0, e.cyc});
          check({4'h0, flags}, {4'h0, e.fl});
          check({6'h0, g_acc, f_acc}, {6'h0, e.grant, e.fault});
        end
        g_acc = 1'b0;
        f_acc = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Driving
  // ---------------------------------------------------------------
  task automatic issue(input cfcc_class_t c, input logic s,
                       input logic [7:0] a);
    cfcc_exp_t e;
    logic      bm;
    int        n;
    valid = 1'b1;
    cls = c;
    skip = s;
    addr = a;
    alu = 4'($random(seed));
    stk = 4'($random(seed));
    n = 0;
    while (ready !== 1'b1 && n < 10)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (ready !== 1'b1)
    begin
      n_fail++;
      end_of_test();
    end
    bm = (c == CL_BIT_SKIP_MEM) || (c == CL_BIT_WRITE_MEM);
    e.grant = bm && (a <= 8'h3F);
    e.fault = bm && (a > 8'h3F);
    e.cyc = 2'h1;
    if (c == CL_BRANCH || c == CL_INDEXED)
      e.cyc = 2'h2;
    if ((c == CL_CMP_SKIP || c == CL_CNT_SKIP || c == CL_BIT_SKIP_IO ||
         (c == CL_BIT_SKIP_MEM && a <= 8'h3F)) && s)
      e.cyc = 2'h2;
    case (c)
      CL_ARITH, CL_CMP_SKIP, CL_CNT_SKIP: model_fl = alu;
      CL_LOGIC, CL_LOAD_ACC: model_fl.zero_flag = alu.zero_flag;
      CL_SHIFT, CL_SWAP_CARRY: model_fl.carry_flag = alu.carry_flag;
      CL_POP_FLAGS: model_fl = stk;
      default: ;
    endcase
    e.fl = model_fl;
    exp_q.push_back(e);
    @(posedge ref_clk);
    #1;
  endtask : issue

  task automatic idle_drain(input int cyc);
    valid = 1'b0;
    cls = cfcc_class_t'($unsigned($random(seed)) % 14);
    // Spare edge lets a two-cycle retire reach the monitor first
    repeat (cyc + 1) @(posedge ref_clk);
    #1;
    if (exp_q.size() != 0)
      check(8'hDD, 8'h00);
  endtask : idle_drain

  task automatic do_reset();
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1;
    model_fl = 4'h0;
    check({ready, retire, cycles, flags}, 8'h80);
    rst = 1'b0;
  endtask : do_reset

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [7:0] addrs [4] = '{8'h3F, 8'h40, 8'h00, 8'hFF};
    do_reset();
    for (int i = 0; i < 14; i++)
      for (int s = 0; s < 2; s++)
        issue(cfcc_class_t'(i), s[0], addrs[(i + s) % 4]);
    idle_drain(4);
    for (int k = 0; k < 400; k++)
      if (($random(seed) & 3) == 0)
        idle_drain(1);
      else
        issue(cfcc_class_t'($unsigned($random(seed)) % 14),
              1'($random(seed)), 8'($random(seed)));
    idle_drain(4);
    issue(CL_ARITH, 1'b0, 8'h00);
    do_reset();
    exp_q.delete();
    issue(CL_BRANCH, 1'b0, 8'h00);
    issue(CL_BIT_SKIP_MEM, 1'b1, 8'h40);
    issue(CL_BIT_SKIP_MEM, 1'b1, 8'h3F);
    idle_drain(4);
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end

endmodule : cfcc_core_bench
